//--- flash_pin_consts.svh
/*
 * Constants of the serial flash pin front end: register offsets, field
 * positions, reset values, command codes and timing figures.
 * Assumes it is included by bare name into design files that need it.
 */
//
// Overview of operation
// - Select high puts device in standby; running internal operation still completes.
// - Select high: all other inputs except the reset pin ignored, all outputs high impedance; sck still clocks the mode and transmit synchronisers.
// - Dedicated reset pin keeps acting while select is high.
// - Host drives select low; device becomes active and takes serial traffic.
// - Command bits are captured on rising serial clock edges in every rate.
// - Single rate: inputs captured on rising edges, output changes on falling edges.
// - Double rate: inputs captured and outputs driven on both clock edges.
// - Reset pin low holds the device in reset with outputs high impedance.
// - Reset during an internal operation aborts it; data may be corrupted.
// - Reset pin ignored when bit 4 of either configuration register disables it.
// - Shared reset/io_line_3 pin: reset disabled under quad_io_protocol, pin is data.
// - Single line commands: io_line_0 is input, io_line_1 output, upper lines unused.
// - Quad commands and quad_io_protocol use all four lines both ways.
`ifndef FLASH_PIN_CONSTS_SVH
`define FLASH_PIN_CONSTS_SVH

// Register byte offsets
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_CMD       8'h08
`define REG_RXDATA    8'h0c
`define REG_TXDATA    8'h10
`define REG_NVCFG     8'h14
`define REG_EVCFG     8'h18

// Control fields
`define CTRL_DTR      0
`define CTRL_QUAD     1
`define CTRL_START    2

// Status fields
`define ST_ACTIVE     0
`define ST_BUSY       1
`define ST_ABORTED    2
`define ST_IN_RESET   3
`define ST_RX_NEW     4
`define ST_CMD_NEW    5

// Configuration: bit 4 low disables the reset function
`define CFG_RST_EN    4
`define CFG_RESET     8'hff

// Serial command that makes the device drive data
`define CMD_READ      8'h03

// Internal operation time and core clock period
`define OP_TIME_NS    20000
`define CLK_NS        20
`define OP_CYCLES     ((`OP_TIME_NS + `CLK_NS - 1) / `CLK_NS)

// Lane enables (active low) for output phases
`define OE_SINGLE     4'hd
`define OE_QUAD       4'h0
`define OE_OFF        4'hf

`endif

//--- flash_pin_pkg.sv
/*
 * Types shared by the serial flash pin front end.
 * Assumes the constants header is compiled alongside.
 */
package flash_pin_pkg;

    // Serial decoder phase
    typedef enum logic [1:0] {
        PH_CMD = 2'b00,
        PH_IN  = 2'b01,
        PH_OUT = 2'b10
    } phase_t;

    typedef logic [7:0] byte_t;
    typedef logic [3:0] lanes_t;

endpackage

//--- flash_pin_front.sv
/*
 * Pin front end of a multi-I/O serial flash: select gating, serial clock
 * edge usage in single and double rate, reset pin handling, APB registers.
 * Assumes an APB master on core_clk and a host SPI controller that drives
 * select_n, sck and the io lines; the io wires are resolved outside.
 */
`timescale 1ns/1ps
`include "flash_pin_consts.svh"

module flash_pin_front #(
    parameter bit SHARED_RESET = 1'b0,
    parameter int OP_COUNT     = `OP_CYCLES
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  sck,
    input  wire logic                  select_n,
    input  wire logic                  reset_n,
    input  wire flash_pin_pkg::lanes_t io_line_in,
    output flash_pin_pkg::lanes_t      io_line_out,
    output flash_pin_pkg::lanes_t      io_line_oe_n
);
    import flash_pin_pkg::*;

    // Picks the data unit for an output edge
    function automatic lanes_t get_unit(input byte_t tx, input logic [2:0] idx,
                                        input logic quad);
        if (quad)
            get_unit = idx[0] ? tx[3:0] : tx[7:4];
        else
            get_unit = {2'b00, tx[3'd7 - idx], 1'b0};
    endfunction

    // Shifts one input unit into a byte
    function automatic byte_t shift_in(input byte_t sh, input lanes_t bits,
                                       input logic quad);
        if (quad)
            shift_in = {sh[3:0], bits};
        else
            shift_in = {sh[6:0], bits[0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Core domain: registers and pin synchronisers

    logic        dtr_r, quad_r;
    byte_t       tx_r, nvcfg_r, evcfg_r, cmd_r, rx_r;
    logic        busy_r, aborted_r, rx_new_r, cmd_new_r, hold_r;
    logic [15:0] op_cnt_r;
    logic        sel_s1_r, sel_s2_r, rp_s1_r, rp_s2_r;
    logic        d3_s1_r, d3_s2_r;
    logic [2:0]  ctog_s_r, rtog_s_r;
    logic [31:0] prdata_r;
    logic        pready_r, pslverr_r;
    logic        wr_en, rd_en, dev_reset, reset_src, cmd_evt, rx_evt;

    // Link domain signals read by the core
    byte_t       cmd_hold_r, rx_hold_r;
    logic        cmd_tog_r, rx_tog_r;

    assign wr_en     = psel & penable & ~pready_r & pwrite;
    assign rd_en     = psel & penable & ~pready_r & ~pwrite;
    assign reset_src = SHARED_RESET ? d3_s2_r : rp_s2_r;
    assign cmd_evt   = ctog_s_r[2] ^ ctog_s_r[1];
    assign rx_evt    = rtog_s_r[2] ^ rtog_s_r[1];

    // Effective reset: ignored by config bit 4 or shared pin in quad
    // Both pin sources are synchronised before the mux, so it never sees a metastable level
    assign dev_reset = ~reset_src
                     & nvcfg_r[`CFG_RST_EN] & evcfg_r[`CFG_RST_EN]
                     & ~(SHARED_RESET & quad_r);

    // Two-flop synchronisers for pins and link toggles
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sel_s1_r <= 1'b1;
            sel_s2_r <= 1'b1;
            rp_s1_r  <= 1'b1;
            rp_s2_r  <= 1'b1;
            d3_s1_r  <= 1'b1;
            d3_s2_r  <= 1'b1;
            ctog_s_r <= 3'h0;
            rtog_s_r <= 3'h0;
        end else begin
            sel_s1_r <= select_n;
            sel_s2_r <= sel_s1_r;
            rp_s1_r  <= reset_n;
            rp_s2_r  <= rp_s1_r;
            d3_s1_r  <= io_line_in[3];
            d3_s2_r  <= d3_s1_r;
            ctog_s_r <= {ctog_s_r[1:0], cmd_tog_r};
            rtog_s_r <= {rtog_s_r[1:0], rx_tog_r};
        end
    end

    // Decoder hold: set by reset, released only while select is high
    // Releasing only with select high forces a fresh falling edge before decoding
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            hold_r <= 1'b1;
        else if (dev_reset)
            hold_r <= 1'b1;
        else if (sel_s2_r)
            hold_r <= 1'b0;
    end

    // Software-written control and configuration
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dtr_r   <= 1'b0;
            quad_r  <= 1'b0;
            tx_r    <= 8'h00;
            nvcfg_r <= `CFG_RESET;
            evcfg_r <= `CFG_RESET;
        end else if (wr_en) begin
            case (paddr)
                `REG_CTRL: begin
                    dtr_r  <= pwdata[`CTRL_DTR];
                    quad_r <= pwdata[`CTRL_QUAD];
                end
                `REG_TXDATA: tx_r    <= pwdata[7:0];
                `REG_NVCFG:  nvcfg_r <= pwdata[7:0];
                `REG_EVCFG:  evcfg_r <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Internal operation: survives select high, aborted by reset
    // Select is never looked at here, so standby cannot cut an operation short
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busy_r    <= 1'b0;
            op_cnt_r  <= 16'h0000;
            aborted_r <= 1'b0;
        end else begin
            if (busy_r && dev_reset) begin
                busy_r <= 1'b0;
            end else if (busy_r) begin
                op_cnt_r <= op_cnt_r - 16'h0001;
                if (op_cnt_r == 16'h0001)
                    busy_r <= 1'b0;
            end else if (wr_en && paddr == `REG_CTRL && pwdata[`CTRL_START]
                         && !dev_reset) begin
                busy_r   <= 1'b1;
                op_cnt_r <= 16'(OP_COUNT);
            end
            aborted_r <= (busy_r & dev_reset) | (aborted_r & ~(wr_en
                         && paddr == `REG_STATUS && pwdata[`ST_ABORTED]));
        end
    end

    // Received command and data, flags set wins over clear
    // The held bytes change on the same sck edge as their toggle, which the core
    // sees only after the synchroniser flops, so it copies them without catching a changing bit
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmd_r     <= 8'h00;
            rx_r      <= 8'h00;
            cmd_new_r <= 1'b0;
            rx_new_r  <= 1'b0;
        end else begin
            if (cmd_evt)
                cmd_r <= cmd_hold_r;
            if (rx_evt)
                rx_r <= rx_hold_r;
            cmd_new_r <= cmd_evt | (cmd_new_r & ~(wr_en && paddr == `REG_STATUS
                         && pwdata[`ST_CMD_NEW]));
            rx_new_r  <= rx_evt | (rx_new_r & ~(wr_en && paddr == `REG_STATUS
                         && pwdata[`ST_RX_NEW]));
        end
    end

    // APB answer: one wait state, error on unmapped offsets
    // Read data stays zero outside the answer cycle so stale values never leak
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= psel & penable & ~pready_r;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            if (psel && penable && !pready_r) begin
                case (paddr)
                    `REG_CTRL:   prdata_r <= {30'h0, quad_r, dtr_r};
                    `REG_STATUS: prdata_r <= {26'h0, cmd_new_r, rx_new_r, hold_r,
                                              aborted_r, busy_r, ~sel_s2_r};
                    `REG_CMD:    prdata_r <= {24'h0, cmd_r};
                    `REG_RXDATA: prdata_r <= {24'h0, rx_r};
                    `REG_TXDATA: prdata_r <= {24'h0, tx_r};
                    `REG_NVCFG:  prdata_r <= {24'h0, nvcfg_r};
                    `REG_EVCFG:  prdata_r <= {24'h0, evcfg_r};
                    default:     pslverr_r <= 1'b1;
                endcase
            end
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    ////////////////////////////////////////////////////////////////////////
    // Link domain: serial decoder on sck, reset by select high or hold

    logic        link_rst;
    phase_t      phase_r;
    byte_t       sh_r, tx_s1_r, tx_s2_r, sh1, sh2;
    logic [3:0]  cnt_r, step, cnt_nxt;
    lanes_t      neg_q_r, p_q_r, n_q_r, oe_n_r;
    logic [2:0]  up_r, un_r, umask;
    logic [1:0]  dtr_s_r, quad_s_r;
    logic        dtr_l, quad_l;

    // Select high ignores the data lines and tristates outputs; the reset pin still acts and sck still clocks the mode and transmit synchronisers
    // A cut frame loses its partial byte; the next frame starts with a command
    assign link_rst = select_n | hold_r;
    assign dtr_l    = dtr_s_r[1];
    assign quad_l   = quad_s_r[1];
    assign umask    = quad_l ? 3'h1 : 3'h7;

    // Mode and transmit byte brought into the link domain
    // The byte is not gray coded: the host must keep mode and transmit data
    // settled for two sck edges before select falls, or a torn value goes out
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            dtr_s_r  <= 2'b00;
            quad_s_r <= 2'b00;
            tx_s1_r  <= 8'h00;
            tx_s2_r  <= 8'h00;
        end else begin
            dtr_s_r  <= {dtr_s_r[0], dtr_r};
            quad_s_r <= {quad_s_r[0], quad_r};
            tx_s1_r  <= tx_r;
            tx_s2_r  <= tx_s1_r;
        end
    end

    // Falling-edge input capture for double rate
    // Only double rate reads this flop; single rate leaves it unused
    always_ff @(negedge sck or posedge link_rst) begin
        if (link_rst)
            neg_q_r <= 4'h0;
        else
            neg_q_r <= io_line_in;
    end

    // Next shift value and bit count for this rising edge
    always_comb begin
        sh1  = shift_in(sh_r, io_line_in, quad_l);
        sh2  = shift_in(shift_in(sh_r, neg_q_r, quad_l), io_line_in, quad_l);
        step = quad_l ? 4'h4 : 4'h1;
        if (phase_r == PH_IN && dtr_l)
            step = {step[2:0], 1'b0};
        cnt_nxt = cnt_r + step;
    end

    // Rising-edge decoder: command first, then a data byte in or out
    // Output phase holds here until select rises; the output flops count units
    always_ff @(posedge sck or posedge link_rst) begin
        if (link_rst) begin
            phase_r <= PH_CMD;
            sh_r    <= 8'h00;
            cnt_r   <= 4'h0;
        end else begin
            case (phase_r)
                PH_CMD: begin
                    sh_r  <= sh1;
                    cnt_r <= cnt_nxt;
                    if (cnt_nxt[3]) begin
                        cnt_r   <= 4'h0;
                        phase_r <= (sh1 == `CMD_READ) ? PH_OUT : PH_IN;
                    end
                end
                PH_IN: begin
                    sh_r  <= dtr_l ? sh2 : sh1;
                    cnt_r <= cnt_nxt[3] ? 4'h0 : cnt_nxt;
                end
                PH_OUT: ;
                default: phase_r <= PH_CMD;
            endcase
        end
    end

    // Command and data bytes handed to the core by toggle
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            cmd_hold_r <= 8'h00;
            rx_hold_r  <= 8'h00;
            cmd_tog_r  <= 1'b0;
            rx_tog_r   <= 1'b0;
        end else if (!link_rst && cnt_nxt[3]) begin
            if (phase_r == PH_CMD) begin
                cmd_hold_r <= sh1;
                cmd_tog_r  <= ~cmd_tog_r;
            end else if (phase_r == PH_IN) begin
                rx_hold_r <= dtr_l ? sh2 : sh1;
                rx_tog_r  <= ~rx_tog_r;
            end
        end
    end

    // Falling-edge output: every unit in single rate, even units in double
    // Each edge flop folds in the other's value, so their XOR is the unit
    // without gating the clock; enables turn on at a falling edge and off at link reset
    always_ff @(negedge sck or posedge link_rst) begin
        if (link_rst) begin
            n_q_r  <= 4'h0;
            un_r   <= 3'h0;
            oe_n_r <= `OE_OFF;
        end else if (phase_r == PH_OUT) begin
            oe_n_r <= quad_l ? `OE_QUAD : `OE_SINGLE;
            n_q_r  <= get_unit(tx_s2_r, un_r & umask, quad_l) ^ p_q_r;
            un_r   <= (un_r + (dtr_l ? 3'h2 : 3'h1)) & umask;
        end
    end

    // Rising-edge output of odd units in double rate
    always_ff @(posedge sck or posedge link_rst) begin
        if (link_rst) begin
            p_q_r <= 4'h0;
            up_r  <= 3'h1;
        end else if (phase_r == PH_OUT && dtr_l) begin
            p_q_r <= get_unit(tx_s2_r, up_r & umask, quad_l) ^ n_q_r;
            up_r  <= (up_r + 3'h2) & umask;
        end
    end

    // Both-edge data recombined from the two edge flops
    assign io_line_out  = p_q_r ^ n_q_r;
    assign io_line_oe_n = oe_n_r;

endmodule

//--- flash_pin_front_checker.sv
/*
 * Port checker of the flash pin front end: APB answer timing and lane
 * release while deselected.
 * Assumes it is bound into flash_pin_front by the testbench.
 */
`timescale 1ns/1ps

module flash_pin_front_checker (
    input wire logic                  core_clk,
    input wire logic                  rst,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  select_n,
    input wire flash_pin_pkg::lanes_t io_line_oe_n
);
    import flash_pin_pkg::*;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////
    // Lane enables
    property p_deselect_hiz; select_n |-> io_line_oe_n == 4'hf; endproperty
    a_deselect_hiz: assert property (p_deselect_hiz)
        else $error("lane driven while deselected");
    property p_lane_set; io_line_oe_n inside {4'hf, 4'hd, 4'h0}; endproperty
    a_lane_set: assert property (p_lane_set)
        else $error("illegal lane enable pattern");

    ////////////////////////////////////////
    // APB answer
    property p_answer; psel && penable && !pready |=> pready; endproperty
    a_answer: assert property (p_answer)
        else $error("no answer one cycle after request");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse)
        else $error("ready longer than one cycle");
    property p_ready_access; pready |-> psel && penable; endproperty
    a_ready_access: assert property (p_ready_access)
        else $error("ready outside access phase");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("error without ready");
    property p_idle_zero; !pready |-> prdata == 32'h0; endproperty
    a_idle_zero: assert property (p_idle_zero)
        else $error("read data outside answer");
    property p_err_zero; pslverr |-> prdata == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero)
        else $error("read data on refused access");

    c_err: cover property (pslverr);
    c_single: cover property (io_line_oe_n == 4'hd);
    c_quad: cover property (io_line_oe_n == 4'h0);
endmodule

//--- spi_host_model.sv
/*
 * Host SPI controller in mode 0 for the flash pin front end.
 * Assumes the bench resolves each io wire from both enables.
 */
`timescale 1ns/1ps

module spi_host_model (
    output logic                  sck,
    output logic                  select_n,
    output flash_pin_pkg::lanes_t io_drv,
    output flash_pin_pkg::lanes_t io_en,
    input  wire flash_pin_pkg::lanes_t io_in
);
    import flash_pin_pkg::*;

    // Idle: deselected, clock still, lane 3 held high
    initial begin
        sck = 1'b0;
        select_n = 1'b1;
        io_en = 4'h8;
        io_drv = 4'h8;
    end

    // Lanes of one unit: a bit on lane 0 or a nibble on all four
    function automatic lanes_t unit(byte_t b, int k, bit q);
        return q ? (k == 0 ? b[7:4] : b[3:0]) : {3'b100, b[7 - k]};
    endfunction

    // One frame: command, then a byte in or, for a read, a byte out
    task automatic frame(input byte_t cmd, input byte_t d, input bit q, input bit dr,
                         output byte_t rx);
        int u;
        int p;
        int k;
        u = q ? 2 : 8;
        p = dr ? 2 * u - 1 : 2 * u;
        rx = 8'h00;
        #7;
        repeat (4) #80 sck = !sck;
        #40 select_n = 1'b0;
        io_en <= q ? 4'hf : 4'h9;
        #40;
        for (int h = 0; h < (dr ? 3 * u : 4 * u); h++) begin
            k = dr ? h - p : (h - p) / 2;
            if (h < p)
                io_drv <= unit(cmd, h / 2, q);
            else if (cmd != 8'h03 && k < u)
                io_drv <= unit(d, k, q);
            if (cmd == 8'h03 && h == 2 * u - 1)
                io_en <= q ? 4'h0 : 4'h8;
            #40;
            if (cmd == 8'h03 && h >= 2 * u && (dr || h % 2 == 0))
                rx = q ? {rx[3:0], io_in} : {rx[6:0], io_in[1]};
            #40 sck = !sck;
        end
        #80 select_n = 1'b1;
        io_en <= 4'h8;
        io_drv <= 4'h8;
    endtask
endmodule

//--- serial_flash_pin_interface_tb.sv
/*
 * Testbench of the flash pin front end: registers, frames in all modes,
 * internal operation and reset pin handling.
 * Assumes the host model and checker are compiled before it.
 */
`timescale 1ns/1ps

`define check(nm, exp, got) \
    compares++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("unexpected %s exp %h got %h", nm, exp, got); \
    end

module serial_flash_pin_interface_tb;
    import flash_pin_pkg::*;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] data;
        logic        err;
    } row_t;

    localparam int OPS = 30;
    logic        core_clk;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sck;
    logic        select_n;
    logic        reset_n = 1'b1;
    lanes_t      io_in;
    lanes_t      io_out;
    lanes_t      io_oe_n;
    lanes_t      io_drv;
    lanes_t      io_en;
    logic [31:0] rd;
    logic        er;
    byte_t       rx;
    logic        drove = 1'b0;
    int          compares = 0;
    int          miscompares = 0;
    row_t        rows[8] = '{'{8'h00, 32'h0, 1'b0}, '{8'h08, 32'h0, 1'b0},
                             '{8'h0c, 32'h0, 1'b0}, '{8'h10, 32'h0, 1'b0},
                             '{8'h14, 32'hff, 1'b0}, '{8'h18, 32'hff, 1'b0},
                             '{8'h1c, 32'h0, 1'b1}, '{8'hfc, 32'h0, 1'b1}};

    flash_pin_front #(
        .OP_COUNT(OPS)
    ) flash_pin_front_inst (
        .core_clk     (core_clk),
        .rst          (rst),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .sck          (sck),
        .select_n     (select_n),
        .reset_n      (reset_n),
        .io_line_in   (io_in),
        .io_line_out  (io_out),
        .io_line_oe_n (io_oe_n)
    );

    spi_host_model spi_host_model_inst (
        .sck      (sck),
        .select_n (select_n),
        .io_drv   (io_drv),
        .io_en    (io_en),
        .io_in    (io_in)
    );

    // Wire level: device, else host, else inverse of the last host value
    assign io_in = (~io_oe_n & io_out) | (io_oe_n & io_en & io_drv) | (io_oe_n & ~io_en & ~io_drv);

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Flags any lane driven while the reset pin is low
    always @(posedge core_clk) begin
        if (!reset_n && io_oe_n !== 4'hf)
            drove <= 1'b1;
    end

    ////////////////////////////////////////
    // One APB transfer, result left in rd and er
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            finish_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reset pin low for four core cycles
    task automatic pin_reset();
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic finish_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            apb(1'b0, rows[i].addr, 32'h0);
            `check("rdata", rows[i].data, rd)
            `check("slverr", rows[i].err, er)
        end
        $display("registers done");
        apb(1'b1, 8'h10, 32'ha5);
        for (byte_t m = 0; m < 4; m++) begin
            apb(1'b1, 8'h00, {24'h0, m});
            spi_host_model_inst.frame(8'h9c, 8'h3c ^ m, m[1], m[0], rx);
            apb(1'b0, 8'h0c, 32'h0);
            `check("rxdata", {24'h0, 8'h3c ^ m}, rd)
            apb(1'b0, 8'h08, 32'h0);
            `check("cmd", 32'h9c, rd)
            spi_host_model_inst.frame(8'h03, 8'h00, m[1], m[0], rx);
            `check("txbyte", 8'ha5, rx)
        end
        $display("modes done");
        apb(1'b0, 8'h04, 32'h0);
        `check("status", 32'h30, rd)
        apb(1'b1, 8'h04, 32'h30);
        apb(1'b0, 8'h04, 32'h0);
        `check("status", 32'h0, rd)
        apb(1'b1, 8'h00, 32'h4);
        apb(1'b0, 8'h04, 32'h0);
        `check("busy", 1'b1, rd[1])
        repeat (OPS + 4) @(posedge core_clk);
        apb(1'b0, 8'h04, 32'h0);
        `check("busy", 1'b0, rd[1])
        $display("operation done");
        apb(1'b1, 8'h00, 32'h4);
        pin_reset();
        apb(1'b0, 8'h04, 32'h0);
        `check("abort", 2'b10, rd[2:1])
        apb(1'b1, 8'h04, 32'h4);
        reset_n <= 1'b0;
        spi_host_model_inst.frame(8'h03, 8'h00, 1'b0, 1'b0, rx);
        @(posedge core_clk);
        reset_n <= 1'b1;
        `check("drove", 1'b0, drove)
        spi_host_model_inst.frame(8'h03, 8'h00, 1'b0, 1'b0, rx);
        `check("txbyte", 8'ha5, rx)
        $display("reset pin done");
        apb(1'b1, 8'h18, 32'hef);
        apb(1'b1, 8'h00, 32'h4);
        pin_reset();
        apb(1'b0, 8'h04, 32'h0);
        `check("ignored", 2'b01, rd[2:1])
        $display("reset disable done");
        finish_test();
    end

    // Watchdog
    initial begin
        #200000;
        miscompares++;
        finish_test();
    end
endmodule

bind flash_pin_front flash_pin_front_checker flash_pin_front_checker_inst (
    .core_clk     (core_clk),
    .rst          (rst),
    .psel         (psel),
    .penable      (penable),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .select_n     (select_n),
    .io_line_oe_n (io_line_oe_n)
);
